// >>> include/fifo_status_pkg.sv
// Constants, types and helpers shared by the FIFO status register block
package fifo_status_pkg;

   // Byte offsets on the register bus
   localparam logic [7:0] OFS_TX_STATUS = 8'h2C;
   localparam logic [7:0] OFS_RX_STATUS = 8'h30;
   localparam logic [7:0] OFS_SEC_STATUS = 8'h34;

   // Field positions; bit 31 of the register is the MSB of the word
   localparam int POS_FULL = 31;
   localparam int POS_AFULL = 30;
   localparam int POS_AEMPTY = 29;
   localparam int POS_EMPTY = 28;
   localparam int POS_COUNT_HI = 24;
   localparam int POS_COUNT_LO = 16;
   localparam int POS_MARKER = 15;
   localparam int POS_FLUSH = 12;
   localparam int POS_SIZE_HI = 8;
   localparam int POS_SIZE_LO = 0;

   // Widths and reset values
   localparam int LEVEL_W = 9;
   localparam logic [8:0] TX_SIZE_RST = 9'h080;
   localparam logic [8:0] RX_SIZE_RST = 9'h08E;
   localparam logic [8:0] SEC_DEPTH = 9'h004;
   localparam logic [31:0] TX_STATUS_RST = 32'h1000_0080;
   localparam logic [31:0] RX_STATUS_RST = 32'h1000_008E;
   localparam logic [31:0] SEC_STATUS_RST = 32'h1000_0000;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

   // Almost-full flavours
   localparam logic AFULL_HAS_ROOM = 1'b0;
   localparam logic AFULL_LAST_SLOT = 1'b1;

   // Bus handshake states
   typedef enum logic {HS_IDLE = 1'b0, HS_ACK = 1'b1} hs_state_t;

   // Places the four occupancy flags into their status word positions
   function automatic logic [31:0] flag_word(input logic full, input logic afull,
                                             input logic aempty, input logic empty);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[POS_FULL] = full;
      w[POS_AFULL] = afull;
      w[POS_AEMPTY] = aempty;
      w[POS_EMPTY] = empty;
      return w;
   endfunction : flag_word

endpackage : fifo_status_pkg

// >>> rtl/bus_handshake.sv
// Avalon-MM waitrequest handshake: one wait cycle, then one accept cycle
`timescale 1ns/100ps
module bus_handshake (
   input wire logic clk,
   input wire logic nrst,
   input wire logic req,
   output logic waitrequest_r,
   output logic load,
   output logic accept
);
   import fifo_status_pkg::*;

   hs_state_t state_r;
   hs_state_t state_nxt;

   // Waitrequest stays high at rest so a new request never completes unseen
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         HS_IDLE: begin
            if (req) begin
               state_nxt = HS_ACK;
            end
         end
         HS_ACK: state_nxt = HS_IDLE;
         default: state_nxt = HS_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_r <= HS_IDLE;
         waitrequest_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         waitrequest_r <= (state_nxt != HS_ACK);
      end
   end

   assign load = req && (state_r == HS_IDLE);
   assign accept = req && (state_r == HS_ACK);

endmodule : bus_handshake

// >>> rtl/fifo_level.sv
// Occupancy counter and registered flags for one quadlet FIFO
`timescale 1ns/100ps
module fifo_level (
   input wire logic clk,
   input wire logic nrst,
   input wire logic push,
   input wire logic pop,
   input wire logic clear,
   input wire logic afull_mode,
   input wire logic [8:0] capacity,
   output logic [8:0] count_r,
   output logic full_r,
   output logic afull_r,
   output logic aempty_r,
   output logic empty_r
);
   import fifo_status_pkg::*;

   logic push_ok;
   logic pop_ok;
   logic [8:0] count_nxt;
   logic full_nxt;

   // A shrunk capacity below the fill level simply reads as full
   assign push_ok = push && !full_r;
   assign pop_ok = pop && !empty_r;

   always_comb begin
      if (clear) begin
         count_nxt = 9'h000;
      end else if (push_ok && !pop_ok) begin
         count_nxt = 9'(count_r + 9'h001);
      end else if (pop_ok && !push_ok) begin
         count_nxt = 9'(count_r - 9'h001);
      end else begin
         count_nxt = count_r;
      end
   end

   assign full_nxt = (count_nxt >= capacity);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         count_r <= 9'h000;
      end else begin
         count_r <= count_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         full_r <= 1'b0;
         afull_r <= 1'b0;
         aempty_r <= 1'b0;
         empty_r <= 1'b1;
      end else begin
         full_r <= full_nxt;
         if (afull_mode == AFULL_LAST_SLOT) begin
            afull_r <= (capacity != 9'h000) && (count_nxt == 9'(capacity - 9'h001));
         end else begin
            afull_r <= !full_nxt;
         end
         aempty_r <= (count_nxt == 9'h001);
         empty_r <= (count_nxt == 9'h000);
      end
   end

endmodule : fifo_level

// >>> rtl/link_fifo_status_regs.sv
// Status and control registers for the async transmit, async receive and secondary transmit FIFOs
//
// Function
// - Tx full flag; pushes dropped when full
// - Tx almost-full means room for one more
// - Tx almost-empty exactly at one quadlet
// - Tx empty flag; reset and bus reset set
// - Tx flush bit empties FIFO, self-clears
// - Tx size field sets capacity, keeps on bus reset
// - Tx register resets 1000_0080; bus reset partial
// - Rx full flag; pushes dropped; bus reset zeroes
// - Rx almost-full means room for one more
// - Rx almost-empty exactly at one quadlet
// - Rx empty flag; reset and bus reset set
// - Rx fill count field, zeroed by bus reset
// - Packet-start marker follows first-quadlet reads
// - Rx flush bit discards entries, self-clears
// - Rx size field sets capacity, keeps on bus reset
// - Rx register resets 1000_008E; size kept
// - Secondary queue full flag; pushes ignored
// - Secondary almost-full at last free slot
// - Secondary almost-empty exactly at one quadlet
// - Secondary empty flag; reset and bus reset set
// - Secondary flush bit empties queue, self-clears
// - Secondary register resets 1000_0000, bus reset restores
`timescale 1ns/100ps
module link_fifo_status_regs (
   input wire logic CLK_SYS,
   input wire logic NRST,
   input wire logic [7:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic BUS_RESET,
   input wire logic TX_PUSH,
   input wire logic TX_POP,
   input wire logic RX_PUSH,
   input wire logic RX_POP,
   input wire logic RX_POP_FIRST,
   input wire logic SEC_PUSH,
   input wire logic SEC_POP,
   output logic TX_FULL,
   output logic RX_FULL,
   output logic SEC_FULL,
   output logic TX_FLUSH,
   output logic RX_FLUSH,
   output logic SEC_FLUSH,
   output logic RX_PACKET_START
);
   import fifo_status_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic bus_req;
   logic bus_load;
   logic bus_accept;
   logic hs_waitrequest;
   logic wr_tx;
   logic wr_rx;
   logic wr_sec;

   logic [8:0] tx_capacity_r;
   logic [8:0] rx_capacity_r;
   logic tx_flush_r;
   logic rx_flush_r;
   logic sec_flush_r;
   logic rx_marker_r;

   logic tx_clear;
   logic rx_clear;
   logic sec_clear;

   logic [8:0] tx_count;
   logic tx_full;
   logic tx_afull;
   logic tx_aempty;
   logic tx_empty;
   logic [8:0] rx_count;
   logic rx_full;
   logic rx_afull;
   logic rx_aempty;
   logic rx_empty;
   logic [8:0] sec_count;
   logic sec_full;
   logic sec_afull;
   logic sec_aempty;
   logic sec_empty;

   logic [31:0] tx_word;
   logic [31:0] rx_word;
   logic [31:0] sec_word;
   logic [31:0] read_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // Register bus handshake

   assign bus_req = AVS_READ || AVS_WRITE;

   bus_handshake u_handshake (
      .clk(CLK_SYS),
      .nrst(NRST),
      .req(bus_req),
      .waitrequest_r(hs_waitrequest),
      .load(bus_load),
      .accept(bus_accept)
   );

   assign AVS_WAITREQUEST = hs_waitrequest;

   // A write lands only at the edge where waitrequest is seen low
   assign wr_tx = bus_accept && AVS_WRITE && (AVS_ADDRESS == OFS_TX_STATUS);
   assign wr_rx = bus_accept && AVS_WRITE && (AVS_ADDRESS == OFS_RX_STATUS);
   assign wr_sec = bus_accept && AVS_WRITE && (AVS_ADDRESS == OFS_SEC_STATUS);

   ////////////////////////////////////////////////////////////////////////////
   // Capacity fields; a bus reset leaves them alone

   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         tx_capacity_r <= TX_SIZE_RST;
      end else if (wr_tx) begin
         tx_capacity_r <= AVS_WRITEDATA[POS_SIZE_HI:POS_SIZE_LO];
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         rx_capacity_r <= RX_SIZE_RST;
      end else if (wr_rx) begin
         rx_capacity_r <= AVS_WRITEDATA[POS_SIZE_HI:POS_SIZE_LO];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flush bits: a new write of one wins over the self-clear

   always_ff @(posedge CLK_SYS) begin
      if (!NRST || BUS_RESET) begin
         tx_flush_r <= 1'b0;
      end else if (wr_tx && AVS_WRITEDATA[POS_FLUSH]) begin
         tx_flush_r <= 1'b1;
      end else if (tx_flush_r && tx_empty) begin
         tx_flush_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!NRST || BUS_RESET) begin
         rx_flush_r <= 1'b0;
      end else if (wr_rx && AVS_WRITEDATA[POS_FLUSH]) begin
         rx_flush_r <= 1'b1;
      end else if (rx_flush_r && rx_empty) begin
         rx_flush_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!NRST || BUS_RESET) begin
         sec_flush_r <= 1'b0;
      end else if (wr_sec && AVS_WRITEDATA[POS_FLUSH]) begin
         sec_flush_r <= 1'b1;
      end else if (sec_flush_r && sec_empty) begin
         sec_flush_r <= 1'b0;
      end
   end

   // Bus reset empties all three just like a flush
   assign tx_clear = tx_flush_r || BUS_RESET;
   assign rx_clear = rx_flush_r || BUS_RESET;
   assign sec_clear = sec_flush_r || BUS_RESET;

   ////////////////////////////////////////////////////////////////////////////
   // Occupancy tracking

   fifo_level u_tx_level (
      .clk(CLK_SYS),
      .nrst(NRST),
      .push(TX_PUSH),
      .pop(TX_POP),
      .clear(tx_clear),
      .afull_mode(AFULL_HAS_ROOM),
      .capacity(tx_capacity_r),
      .count_r(tx_count),
      .full_r(tx_full),
      .afull_r(tx_afull),
      .aempty_r(tx_aempty),
      .empty_r(tx_empty)
   );

   fifo_level u_rx_level (
      .clk(CLK_SYS),
      .nrst(NRST),
      .push(RX_PUSH),
      .pop(RX_POP),
      .clear(rx_clear),
      .afull_mode(AFULL_HAS_ROOM),
      .capacity(rx_capacity_r),
      .count_r(rx_count),
      .full_r(rx_full),
      .afull_r(rx_afull),
      .aempty_r(rx_aempty),
      .empty_r(rx_empty)
   );

   // Secondary queue depth is fixed; its last slot raises almost-full
   fifo_level u_sec_level (
      .clk(CLK_SYS),
      .nrst(NRST),
      .push(SEC_PUSH),
      .pop(SEC_POP),
      .clear(sec_clear),
      .afull_mode(AFULL_LAST_SLOT),
      .capacity(SEC_DEPTH),
      .count_r(sec_count),
      .full_r(sec_full),
      .afull_r(sec_afull),
      .aempty_r(sec_aempty),
      .empty_r(sec_empty)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Packet-start marker

   // Tracks the last quadlet drawn from the receive data port
   always_ff @(posedge CLK_SYS) begin
      if (!NRST || BUS_RESET) begin
         rx_marker_r <= 1'b0;
      end else if (RX_POP && !rx_empty) begin
         rx_marker_r <= RX_POP_FIRST;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status words and read data

   always_comb begin
      tx_word = flag_word(tx_full, tx_afull, tx_aempty, tx_empty);
      tx_word[POS_FLUSH] = tx_flush_r;
      tx_word[POS_SIZE_HI:POS_SIZE_LO] = tx_capacity_r;
   end

   always_comb begin
      rx_word = flag_word(rx_full, rx_afull, rx_aempty, rx_empty);
      rx_word[POS_COUNT_HI:POS_COUNT_LO] = rx_count;
      rx_word[POS_MARKER] = rx_marker_r;
      rx_word[POS_FLUSH] = rx_flush_r;
      rx_word[POS_SIZE_HI:POS_SIZE_LO] = rx_capacity_r;
   end

   always_comb begin
      sec_word = flag_word(sec_full, sec_afull, sec_aempty, sec_empty);
      sec_word[POS_FLUSH] = sec_flush_r;
   end

   // Unmapped addresses read as zero and ignore writes
   always_comb begin
      case (AVS_ADDRESS)
         OFS_TX_STATUS: read_nxt = tx_word;
         OFS_RX_STATUS: read_nxt = rx_word;
         OFS_SEC_STATUS: read_nxt = sec_word;
         default: read_nxt = UNMAPPED_DATA;
      endcase
   end

   // Captured in the wait cycle so data stands when waitrequest drops
   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         AVS_READDATA <= 32'h0000_0000;
      end else if (bus_load && AVS_READ) begin
         AVS_READDATA <= read_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered side outputs

   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         TX_FULL <= 1'b0;
         RX_FULL <= 1'b0;
         SEC_FULL <= 1'b0;
      end else begin
         TX_FULL <= tx_full;
         RX_FULL <= rx_full;
         SEC_FULL <= sec_full;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         TX_FLUSH <= 1'b0;
         RX_FLUSH <= 1'b0;
         SEC_FLUSH <= 1'b0;
         RX_PACKET_START <= 1'b0;
      end else begin
         TX_FLUSH <= tx_clear;
         RX_FLUSH <= rx_clear;
         SEC_FLUSH <= sec_clear;
         RX_PACKET_START <= rx_marker_r;
      end
   end

endmodule : link_fifo_status_regs

// >>> dv/link_fifo_status_chk.sv
// Port checker for the FIFO status register block
`timescale 1ns/100ps
module link_fifo_status_chk (
   input wire logic CLK_SYS,
   input wire logic NRST,
   input wire logic [7:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire logic BUS_RESET,
   input wire logic TX_PUSH,
   input wire logic TX_POP,
   input wire logic RX_PUSH,
   input wire logic RX_POP,
   input wire logic RX_POP_FIRST,
   input wire logic SEC_PUSH,
   input wire logic SEC_POP,
   input wire logic TX_FULL,
   input wire logic RX_FULL,
   input wire logic SEC_FULL,
   input wire logic TX_FLUSH,
   input wire logic RX_FLUSH,
   input wire logic SEC_FLUSH,
   input wire logic RX_PACKET_START
);
   import fifo_status_pkg::*;
   logic [31:0] rsvd;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);
   // Unmapped places are all reserved, so one mask covers them too
   always_comb begin
      rsvd = (AVS_ADDRESS == OFS_TX_STATUS) ? 32'h0FFF_EE00 : (AVS_ADDRESS == OFS_RX_STATUS) ? 32'h0E00_6E00 :
         (AVS_ADDRESS == OFS_SEC_STATUS) ? 32'h0FFF_EFFF : 32'hFFFF_FFFF;
   end
   ////////////////////////////////////////////////////////////////////////
   a_flush_busrst: assert property (BUS_RESET |=> TX_FLUSH && RX_FLUSH && SEC_FLUSH)
      else $error("flush outputs not raised by bus reset");
   a_marker_busrst: assert property (BUS_RESET |=> ##1 !RX_PACKET_START)
      else $error("packet start marker survived bus reset");
   a_full_busrst: assert property (BUS_RESET |=> ##1 !TX_FULL && !RX_FULL && !SEC_FULL)
      else $error("full output survived bus reset");
   a_tx_flush_ends: assert property ($rose(TX_FLUSH) && !BUS_RESET |-> ##[1:4] !TX_FLUSH)
      else $error("tx flush did not clear itself");
   a_rx_flush_ends: assert property ($rose(RX_FLUSH) && !BUS_RESET |-> ##[1:4] $fell(RX_FLUSH))
      else $error("rx flush did not clear itself");
   a_sec_flush_ends: assert property ($rose(SEC_FLUSH) && !BUS_RESET |-> ##[1:4] !SEC_FLUSH)
      else $error("secondary flush did not clear itself");
   a_req_taken: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("request not answered after one wait cycle");
   a_ack_single: assert property ($fell(AVS_WAITREQUEST) |=> AVS_WAITREQUEST)
      else $error("waitrequest low for more than one cycle");
   a_rsvd_zero: assert property (AVS_READ && !AVS_WAITREQUEST |-> (AVS_READDATA & rsvd) == 32'h0000_0000)
      else $error("reserved or unmapped bits read nonzero");
   a_sec_flags_excl: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == OFS_SEC_STATUS
      |-> !(AVS_READDATA[POS_FULL] && AVS_READDATA[POS_EMPTY]))
      else $error("secondary queue full and empty together");
   c_bus_reset: cover property (BUS_RESET);
   c_sec_full: cover property ($rose(SEC_FULL));
   c_marker: cover property ($rose(RX_PACKET_START));
endmodule : link_fifo_status_chk

bind link_fifo_status_regs link_fifo_status_chk link_fifo_status_chk_i (.*);

// >>> dv/fifo_engine_model.sv
// Packet engine model: bursts of push or pop strobes, at full or half rate
`timescale 1ns/100ps
module fifo_engine_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic start,
   input wire logic [2:0] sel,
   input wire logic [8:0] reps,
   input wire logic slow,
   input wire logic first,
   output logic [5:0] strobe,
   output logic pop_first,
   output logic busy
);
   // Initialised so the strobes are defined before the first reset edge
   logic [8:0] left_r = 9'h000;
   logic tick_r = 1'b0;
   logic fire;
   assign busy = left_r != 9'h000;
   assign fire = busy && (!slow || tick_r);
   assign strobe = fire ? (6'h01 << sel) : 6'h00;
   assign pop_first = fire && first;
   always_ff @(posedge clk) begin
      tick_r <= nrst && !tick_r;
      if (!nrst) begin
         left_r <= 9'h000;
      end else if (start) begin
         left_r <= reps;
      end else if (fire) begin
         left_r <= left_r - 9'h001;
      end
   end
endmodule : fifo_engine_model

// >>> dv/testbench.sv
// Self-checking bench for the FIFO status registers
`timescale 1ns/100ps
module testbench;
   import fifo_status_pkg::*;
   logic clk_sys, nrst, rd, wr, wait_req, bus_rst, start, slow, first, busy, pop_first;
   logic tx_full, rx_full, sec_full, tx_flush, rx_flush, sec_flush, rx_start;
   logic [7:0] address;
   logic [31:0] wdata, rdata, seed;
   logic [2:0] sel;
   logic [8:0] reps;
   logic [5:0] strobe;
   logic [31:0] exp_q[$];
   int n_errors = 0;
   int check_count = 0;

   link_fifo_status_regs link_fifo_status_regs_i (.CLK_SYS(clk_sys), .NRST(nrst), .AVS_ADDRESS(address),
      .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
      .BUS_RESET(bus_rst), .TX_PUSH(strobe[0]), .TX_POP(strobe[1]), .RX_PUSH(strobe[2]), .RX_POP(strobe[3]),
      .RX_POP_FIRST(pop_first), .SEC_PUSH(strobe[4]), .SEC_POP(strobe[5]), .TX_FULL(tx_full), .RX_FULL(rx_full),
      .SEC_FULL(sec_full), .TX_FLUSH(tx_flush), .RX_FLUSH(rx_flush), .SEC_FLUSH(sec_flush),
      .RX_PACKET_START(rx_start));
   fifo_engine_model fifo_engine_model_i (.clk(clk_sys), .nrst(nrst), .start(start), .sel(sel), .reps(reps),
      .slow(slow), .first(first), .strobe(strobe), .pop_first(pop_first), .busy(busy));

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      check_count++;
      if (seen !== want) begin
         n_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask : chk

   // For a read, d is the expected word; the monitor compares it
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      if (!w) exp_q.push_back(d);
      address <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk_sys);
      // Only the watchdog ends a wait that never sees waitrequest low
      while (wait_req !== 1'b0) begin
         @(posedge clk_sys);
      end
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk_sys);
   endtask : bus

   task automatic burst(input logic [2:0] s, input logic [8:0] n, input logic f);
      int k;
      k = 0;
      sel <= s;
      reps <= n;
      first <= f;
      slow <= seed[0];
      start <= 1'b1;
      seed = lfsr_next(seed);
      @(posedge clk_sys);
      start <= 1'b0;
      do begin
         @(negedge clk_sys);
         k++;
      end while (busy === 1'b1 && k < 600);
      repeat (3) @(posedge clk_sys);
   endtask : burst

   task automatic flush_wait(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
      repeat (4) @(posedge clk_sys);
   endtask : flush_wait

   task automatic pulse_bus_reset;
      bus_rst <= 1'b1;
      @(posedge clk_sys);
      bus_rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask : pulse_bus_reset

   task automatic close_out;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out

   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk_sys) begin
      if (rd === 1'b1 && wait_req === 1'b0) chk(rdata, exp_q.pop_front());
   end

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      close_out();
   end

   initial begin
      {nrst, rd, wr, bus_rst, start, slow, first, sel, reps, address, wdata} = '0;
      seed = 32'hF139;
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      bus(1'b0, OFS_TX_STATUS, 32'h5000_0080);
      bus(1'b0, OFS_RX_STATUS, 32'h5000_008E);
      bus(1'b0, OFS_SEC_STATUS, SEC_STATUS_RST);
      bus(1'b0, 8'h28, 32'h0000_0000);
      $display("test reset done");
      // Writes to the read-only flags must not stick
      bus(1'b1, OFS_TX_STATUS, 32'hF000_0003);
      bus(1'b0, OFS_TX_STATUS, 32'h5000_0003);
      burst(3'h0, 9'h001, 1'b0);
      bus(1'b0, OFS_TX_STATUS, 32'h6000_0003);
      burst(3'h0, 9'h003, 1'b0);
      bus(1'b0, OFS_TX_STATUS, 32'h8000_0003);
      chk({31'h0, tx_full}, 32'h1);
      burst(3'h1, 9'h002, 1'b0);
      bus(1'b0, OFS_TX_STATUS, 32'h6000_0003);
      flush_wait(OFS_TX_STATUS, 32'h0000_1003);
      bus(1'b0, OFS_TX_STATUS, 32'h5000_0003);
      $display("test tx done");
      bus(1'b1, OFS_RX_STATUS, 32'h0000_0002);
      burst(3'h2, 9'h002, 1'b0);
      bus(1'b0, OFS_RX_STATUS, 32'h8002_0002);
      chk({31'h0, rx_full}, 32'h1);
      flush_wait(OFS_RX_STATUS, 32'h0000_1002);
      bus(1'b0, OFS_RX_STATUS, 32'h5000_0002);
      burst(3'h2, 9'h002, 1'b0);
      burst(3'h3, 9'h001, 1'b1);
      bus(1'b0, OFS_RX_STATUS, 32'h6001_8002);
      chk({31'h0, rx_start}, 32'h1);
      pulse_bus_reset();
      bus(1'b0, OFS_RX_STATUS, 32'h5000_0002);
      bus(1'b0, OFS_TX_STATUS, 32'h5000_0003);
      $display("test rx done");
      burst(3'h4, 9'h003, 1'b0);
      bus(1'b0, OFS_SEC_STATUS, 32'h4000_0000);
      burst(3'h4, 9'h002, 1'b0);
      bus(1'b0, OFS_SEC_STATUS, 32'h8000_0000);
      chk({31'h0, sec_full}, 32'h1);
      burst(3'h5, 9'h003, 1'b0);
      bus(1'b0, OFS_SEC_STATUS, 32'h2000_0000);
      flush_wait(OFS_SEC_STATUS, 32'h0000_1000);
      bus(1'b0, OFS_SEC_STATUS, 32'h1000_0000);
      burst(3'h4, 9'h002, 1'b0);
      pulse_bus_reset();
      bus(1'b0, OFS_SEC_STATUS, SEC_STATUS_RST);
      $display("test secondary done");
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, OFS_SEC_STATUS, seed & 32'hFFFF_EFFF);
         bus(1'b1, 8'h38, seed);
         seed = lfsr_next(seed);
         bus(1'b0, OFS_SEC_STATUS, SEC_STATUS_RST);
         bus(1'b0, 8'h38, 32'h0000_0000);
      end
      $display("test random done");
      close_out();
   end
endmodule : testbench
